// *** design/mac_regs.svh ***
// Constants of the multiply-accumulate unit: APB offsets, fields, resets.
// Assumes it is included by bare name from the modules and the bench files.
`ifndef MAC_REGS_SVH
`define MAC_REGS_SVH

`define MAC_APB_AW          8
`define MAC_OFF_LOW_WORD    8'h00
`define MAC_OFF_HIGH_WORD   8'h04
`define MAC_OFF_EXT_BITS    8'h08
`define MAC_OFF_OPERANDS    8'h0c
`define MAC_OFF_CONTROL     8'h10
`define MAC_CTRL_FMT_BIT    0
`define MAC_CTRL_RND_BIT    1
`define MAC_CTRL_SUM_BIT    2
`define MAC_CTRL_NEG_BIT    3
`define MAC_CTRL_CLEAR_BIT  8
`define MAC_ROUND_BIT       15
`define MAC_ACC_RESET       35'h000000000
`define MAC_CTRL_RESET      4'h0

`endif

// *** design/mac_pkg.sv ***
// Types shared by the multiply-accumulate unit and its product stage.
// Assumes the constants header is on the include path.
package mac_pkg;

    typedef struct packed {
        logic negate;
        logic sum;
        logic round;
        logic fmt;
    } ctrl_t;

    typedef enum logic [1:0] {
        OP_LOAD    = 2'h0,
        OP_ADD     = 2'h1,
        OP_SUB     = 2'h3,
        OP_PRELOAD = 2'h2
    } acc_op_t;

    typedef enum logic [2:0] {
        REG_LOW  = 3'h0,
        REG_HIGH = 3'h1,
        REG_EXT  = 3'h2,
        REG_OPS  = 3'h3,
        REG_CTRL = 3'h4,
        REG_NONE = 3'h7
    } reg_sel_t;

endpackage : mac_pkg

// *** design/mac_prod_if.sv ***
// Carries operands, controls and the extended product between stages.
// Assumes both stages run on the same clock domain.
`timescale 1ns/1ns
interface mac_prod_if #(parameter int OPW = 16, parameter int ACCW = 35);
    logic [OPW-1:0]  x_op;
    logic [OPW-1:0]  y_op;
    logic            fmt;
    logic            round;
    logic [ACCW-1:0] product;

    modport calc (input x_op, input y_op, input fmt, input round,
                  output product);
    modport user (output x_op, output y_op, output fmt, output round,
                  input product);
endinterface : mac_prod_if

// *** design/mac_product.sv ***
// Multiplier stage: full product, extension to accumulator width, round.
// Assumes registered operands and controls arrive over the interface.
`timescale 1ns/1ns
module mac_product #(
    parameter int OPW  = 16,
    parameter int ACCW = 35
) (
    mac_prod_if.calc p
);
    import mac_pkg::*;
    `include "mac_regs.svh"

    logic signed [OPW:0]     x_ext;
    logic signed [OPW:0]     y_ext;
    logic signed [2*OPW+1:0] full;
    logic [ACCW-1:0]         wide;

    // One 17 x 17 signed multiply covers both formats.
    always_comb begin
        x_ext = {p.fmt & p.x_op[OPW-1], p.x_op};
        y_ext = {p.fmt & p.y_op[OPW-1], p.y_op};
        full  = x_ext * y_ext;
        wide  = ACCW'(full);
        p.product = wide + (p.round ? ACCW'(1) << `MAC_ROUND_BIT
                                    : ACCW'(0));
    end

endmodule : mac_product

// *** design/multiply_accumulate_unit.sv ***
// 16 x 16 multiplier with 35-bit accumulator, three shared ports, APB view.
// Assumes all pins, the three operand/product clocks among them, are
// synchronous to clk_sys_in and sampled as ordinary inputs.
`timescale 1ns/1ns
`include "mac_regs.svh"

// Functional notes
// - Multiplicand is 16 bits, signed or unsigned per latched format.
// - Low bus carries multiplier in, low word out, low word preload.
// - High bus outputs accumulator bits 16..31 and preloads them.
// - Extension bus outputs bits 32..34 and preloads them.
// - Format high means two's complement, low means unsigned.
// - Sum mode low loads product; high combines with accumulator.
// - Sum with negate stores product minus accumulator, else sum.
// - Round select adds one at bit 15 of the product.
// - Full 32-bit product is extended to 35 bits.
// - X register takes X clock edges, Y register takes Y clock edges.
// - Four-bit control register loads on either operand clock edge.
// - Accumulator registers change only on product clock edges or a software clear.
// - Product edge loads port data when preloading, else the result.
// - Port load select high floats all three output ports.
// - In preload, each port with enable high loads its register.
// - Low enable high floats low port; low drives the low word.
// - High enable low drives high port; high floats it.
// - Extension enable low drives extension port; high floats it.
// - With load select low, enables only gate their ports.
module multiply_accumulate_unit #(
    parameter int OPW  = 16,
    parameter int EXTW = 3
) (
    // Clock and reset
    input  wire logic                     clk_sys_in,
    input  wire logic                     srst_in,
    // Operand and control pins
    input  wire logic [OPW-1:0]           multiplicand_in,
    input  wire logic                     operand_format_sel_in,
    input  wire logic                     round_sel_in,
    input  wire logic                     sum_mode_sel_in,
    input  wire logic                     negate_mode_sel_in,
    input  wire logic                     x_operand_clk_in,
    input  wire logic                     y_operand_clk_in,
    input  wire logic                     product_clk_in,
    // Port control pins
    input  wire logic                     port_load_sel_in,
    input  wire logic                     low_port_out_en_n_in,
    input  wire logic                     high_port_out_en_n_in,
    input  wire logic                     ext_port_out_en_n_in,
    // Low bus: multiplier in, low product word out
    input  wire logic [OPW-1:0]           multiplier_low_word_bus_in,
    output logic      [OPW-1:0]           multiplier_low_word_bus_out,
    output logic                          multiplier_low_word_bus_oe_out,
    // High product bus
    input  wire logic [OPW-1:0]           high_product_bus_in,
    output logic      [OPW-1:0]           high_product_bus_out,
    output logic                          high_product_bus_oe_out,
    // Extension bus
    input  wire logic [EXTW-1:0]          extension_bus_in,
    output logic      [EXTW-1:0]          extension_bus_out,
    output logic                          extension_bus_oe_out,
    // APB slave
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [`MAC_APB_AW-1:0]   paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out
);
    import mac_pkg::*;

    localparam int ACCW = 2 * OPW + EXTW;

    logic            x_clk_q;
    logic            y_clk_q;
    logic            p_clk_q;
    logic            x_edge;
    logic            y_edge;
    logic            p_edge;
    logic [OPW-1:0]  x_reg;
    logic [OPW-1:0]  y_reg;
    ctrl_t           ctrl;
    logic [OPW-1:0]  low_product_word;
    logic [OPW-1:0]  high_product_word;
    logic [EXTW-1:0] extension_bits;
    logic [ACCW-1:0] acc;
    logic [ACCW-1:0] next_acc;
    acc_op_t         op;
    logic            sw_clear;
    logic            apb_access;
    logic            apb_done;
    reg_sel_t        sel;

    mac_prod_if #(.OPW(OPW), .ACCW(ACCW)) prod_if ();

    mac_product #(
        .OPW  (OPW),
        .ACCW (ACCW)
    ) u_product (
        .p (prod_if.calc)
    );

    function automatic reg_sel_t decode(input logic [`MAC_APB_AW-1:0] a);
        case (a)
            `MAC_OFF_LOW_WORD:  decode = REG_LOW;
            `MAC_OFF_HIGH_WORD: decode = REG_HIGH;
            `MAC_OFF_EXT_BITS:  decode = REG_EXT;
            `MAC_OFF_OPERANDS:  decode = REG_OPS;
            `MAC_OFF_CONTROL:   decode = REG_CTRL;
            default:            decode = REG_NONE;
        endcase
    endfunction : decode

    function automatic acc_op_t op_of(input logic load, input ctrl_t c);
        if (load) begin
            op_of = OP_PRELOAD;
        end else if (!c.sum) begin
            op_of = OP_LOAD;
        end else if (c.negate) begin
            op_of = OP_SUB;
        end else begin
            op_of = OP_ADD;
        end
    endfunction : op_of

    // The three pin clocks are sampled; a rising edge is seen for one cycle.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            x_clk_q <= 1'b0;
            y_clk_q <= 1'b0;
            p_clk_q <= 1'b0;
        end else begin
            x_clk_q <= x_operand_clk_in;
            y_clk_q <= y_operand_clk_in;
            p_clk_q <= product_clk_in;
        end
    end

    assign x_edge = x_operand_clk_in & ~x_clk_q;
    assign y_edge = y_operand_clk_in & ~y_clk_q;
    assign p_edge = product_clk_in & ~p_clk_q;

    // Operand registers.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            x_reg <= '0;
            y_reg <= '0;
        end else begin
            if (x_edge) begin
                x_reg <= multiplicand_in;
            end
            if (y_edge) begin
                y_reg <= multiplier_low_word_bus_in;
            end
        end
    end

    // Control register.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            ctrl <= ctrl_t'(`MAC_CTRL_RESET);
        end else if (x_edge || y_edge) begin
            ctrl.fmt    <= operand_format_sel_in;
            ctrl.round  <= round_sel_in;
            ctrl.sum    <= sum_mode_sel_in;
            ctrl.negate <= negate_mode_sel_in;
        end
    end

    assign prod_if.x_op  = x_reg;
    assign prod_if.y_op  = y_reg;
    assign prod_if.fmt   = ctrl.fmt;
    assign prod_if.round = ctrl.round;

    assign acc = {extension_bits, high_product_word, low_product_word};
    assign op  = op_of(port_load_sel_in, ctrl);

    // Arithmetic wraps at the accumulator width; no overflow is kept.
    always_comb begin
        case (op)
            OP_LOAD: next_acc = prod_if.product;
            OP_ADD:  next_acc = prod_if.product + acc;
            OP_SUB:  next_acc = prod_if.product - acc;
            default: next_acc = acc;
        endcase
    end

    // Accumulator registers; a product edge wins over a software clear.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            {extension_bits, high_product_word, low_product_word}
                <= `MAC_ACC_RESET;
        end else if (p_edge) begin
            if (op == OP_PRELOAD) begin
                if (low_port_out_en_n_in) begin
                    low_product_word <= multiplier_low_word_bus_in;
                end
                if (high_port_out_en_n_in) begin
                    high_product_word <= high_product_bus_in;
                end
                if (ext_port_out_en_n_in) begin
                    extension_bits <= extension_bus_in;
                end
            end else begin
                {extension_bits, high_product_word, low_product_word}
                    <= next_acc;
            end
        end else if (sw_clear) begin
            {extension_bits, high_product_word, low_product_word}
                <= `MAC_ACC_RESET;
        end
    end

    // Enables are registered, so a port follows its pins one cycle late.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            multiplier_low_word_bus_oe_out <= 1'b0;
            high_product_bus_oe_out        <= 1'b0;
            extension_bus_oe_out           <= 1'b0;
        end else begin
            multiplier_low_word_bus_oe_out <= ~port_load_sel_in
                & ~low_port_out_en_n_in;
            high_product_bus_oe_out <= ~port_load_sel_in
                & ~high_port_out_en_n_in;
            extension_bus_oe_out <= ~port_load_sel_in
                & ~ext_port_out_en_n_in;
        end
    end

    assign multiplier_low_word_bus_out = low_product_word;
    assign high_product_bus_out        = high_product_word;
    assign extension_bus_out           = extension_bits;

    // APB slave with one wait state so read data comes from a register.
    assign apb_access = psel_in & penable_in;
    assign apb_done   = apb_access & pready_out;
    assign sel        = decode(paddr_in);

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
        end else begin
            pready_out  <= apb_access & ~pready_out;
            pslverr_out <= apb_access & ~pready_out & (sel == REG_NONE);
            if (apb_access && !pready_out && !pwrite_in) begin
                case (sel)
                    REG_LOW:  prdata_out <= 32'(low_product_word);
                    REG_HIGH: prdata_out <= 32'(high_product_word);
                    REG_EXT:  prdata_out <= 32'(extension_bits);
                    REG_OPS:  prdata_out <= {y_reg, x_reg};
                    REG_CTRL: prdata_out <= 32'(ctrl);
                    default:  prdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // Writing the clear bit zeroes the accumulator one cycle later.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            sw_clear <= 1'b0;
        end else begin
            sw_clear <= apb_done & pwrite_in & (sel == REG_CTRL)
                        & pwdata_in[`MAC_CTRL_CLEAR_BIT];
        end
    end

endmodule : multiply_accumulate_unit

// *** tb/mac_unit_checker.sv ***
// Port checker for the multiply-accumulate unit.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`include "mac_regs.svh"
module mac_unit_checker #(
    parameter int OPW  = 16,
    parameter int EXTW = 3
) (
    // Clock and reset
    input wire logic            clk_sys_in,
    input wire logic            srst_in,
    // Pins
    input wire logic            product_clk_in,
    input wire logic            port_load_sel_in,
    input wire logic            low_port_out_en_n_in,
    input wire logic            high_port_out_en_n_in,
    input wire logic            ext_port_out_en_n_in,
    input wire logic [OPW-1:0]  multiplier_low_word_bus_in,
    input wire logic [OPW-1:0]  high_product_bus_in,
    input wire logic [EXTW-1:0] extension_bus_in,
    // Outputs
    input wire logic [OPW-1:0]  multiplier_low_word_bus_out,
    input wire logic [OPW-1:0]  high_product_bus_out,
    input wire logic [EXTW-1:0] extension_bus_out,
    input wire logic            multiplier_low_word_bus_oe_out,
    input wire logic            high_product_bus_oe_out,
    input wire logic            extension_bus_oe_out,
    input wire logic            pready_out
);
    logic [2:0] quiet;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    // A register write may clear the accumulator, so hold checks wait it out.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || pready_out) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    sequence s_pedge;
        product_clk_in && !$past(product_clk_in);
    endsequence
    sequence s_preload;
        s_pedge ##0 port_load_sel_in;
    endsequence
    property p_float;
        port_load_sel_in [*2] |-> !multiplier_low_word_bus_oe_out
            && !high_product_bus_oe_out && !extension_bus_oe_out;
    endproperty
    property p_low_oe;
        low_port_out_en_n_in |=> !multiplier_low_word_bus_oe_out;
    endproperty
    property p_high_oe;
        !port_load_sel_in && !high_port_out_en_n_in
            |=> high_product_bus_oe_out;
    endproperty
    property p_ext_oe;
        ext_port_out_en_n_in |=> !extension_bus_oe_out;
    endproperty
    property p_hold;
        quiet > 3'h4 && !($past(product_clk_in) && !$past(product_clk_in, 2))
            |-> $stable({extension_bus_out, high_product_bus_out,
                         multiplier_low_word_bus_out});
    endproperty
    property p_pre_low;
        s_preload ##0 low_port_out_en_n_in
            |=> multiplier_low_word_bus_out
                == $past(multiplier_low_word_bus_in);
    endproperty
    property p_pre_high;
        s_preload ##0 high_port_out_en_n_in
            |=> high_product_bus_out == $past(high_product_bus_in);
    endproperty
    property p_pre_ext;
        s_preload ##0 ext_port_out_en_n_in
            |=> extension_bus_out == $past(extension_bus_in);
    endproperty
    property p_pre_keep;
        s_preload ##0 !low_port_out_en_n_in
            |=> $stable(multiplier_low_word_bus_out);
    endproperty
    a_float: assert property (p_float)
        else $error("port driven while preloading");
    a_low_oe: assert property (p_low_oe)
        else $error("low port driven while disabled");
    a_high_oe: assert property (p_high_oe)
        else $error("high port not driven");
    a_ext_oe: assert property (p_ext_oe)
        else $error("extension port driven while disabled");
    a_hold: assert property (p_hold)
        else $error("accumulator moved without product edge");
    a_pre_low: assert property (p_pre_low)
        else $error("low word preload lost");
    a_pre_high: assert property (p_pre_high)
        else $error("high word preload lost");
    a_pre_ext: assert property (p_pre_ext)
        else $error("extension preload lost");
    a_pre_keep: assert property (p_pre_keep)
        else $error("low word loaded with enable low");
endmodule : mac_unit_checker

// *** tb/mac_host_port.sv ***
// Host end of one shared port of the multiply-accumulate unit.
// Assumes the host drives only while the port's active-low enable is high.
`timescale 1ns/1ns
module mac_host_port #(
    parameter int W = 16
) (
    // Clock
    input  wire logic         clk_in,
    // Device side
    input  wire logic [W-1:0] dev_data_in,
    input  wire logic         dev_oe_in,
    // Host side
    input  wire logic [W-1:0] host_data_in,
    input  wire logic         host_en_in,
    // Resolved wire level
    output logic      [W-1:0] wire_out
);
    logic [W-1:0] last = '0;
    // A released wire has no pull, so it toggles rather than keep old data.
    always_comb begin
        if (dev_oe_in) begin
            wire_out = dev_data_in;
        end else if (host_en_in) begin
            wire_out = host_data_in;
        end else begin
            wire_out = ~last;
        end
    end
    always_ff @(posedge clk_in) begin
        last <= wire_out;
    end
endmodule : mac_host_port

// *** tb/multiply_accumulate_unit_bench.sv ***
// Self-checking bench for the multiply-accumulate unit.
// Assumes pin clocks are sampled by clk_sys_in and APB answers with waits.
`timescale 1ns/1ns
`include "mac_regs.svh"
module multiply_accumulate_unit_bench;
    logic        clk_sys_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [15:0] multiplicand_in = '0;
    logic [3:0]  ctl = '0;
    logic [2:0]  pclk = '0;
    logic [2:0]  en_n = '1;
    logic [34:0] hd = '0;
    logic        port_load_sel_in = 1'b0;
    logic        operand_format_sel_in, round_sel_in;
    logic        sum_mode_sel_in, negate_mode_sel_in;
    logic        x_operand_clk_in, y_operand_clk_in, product_clk_in;
    logic        low_port_out_en_n_in, high_port_out_en_n_in;
    logic        ext_port_out_en_n_in;
    logic [15:0] multiplier_low_word_bus_in, multiplier_low_word_bus_out;
    logic [15:0] high_product_bus_in, high_product_bus_out;
    logic [2:0]  extension_bus_in, extension_bus_out;
    logic        multiplier_low_word_bus_oe_out, high_product_bus_oe_out;
    logic        extension_bus_oe_out, pready_out, pslverr_out;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0]  paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, rd;
    logic        er;
    logic [34:0] acc = '0;
    int          bad_count = 0, check_count = 0;
    assign {negate_mode_sel_in, sum_mode_sel_in} = ctl[3:2];
    assign {round_sel_in, operand_format_sel_in} = ctl[1:0];
    assign {product_clk_in, y_operand_clk_in, x_operand_clk_in} = pclk;
    assign {ext_port_out_en_n_in, high_port_out_en_n_in} = en_n[2:1];
    assign low_port_out_en_n_in = en_n[0];
    multiply_accumulate_unit dut (.*);
    mac_host_port #(.W(16)) u_low (.clk_in(clk_sys_in),
        .dev_data_in(multiplier_low_word_bus_out),
        .dev_oe_in(multiplier_low_word_bus_oe_out), .host_data_in(hd[15:0]),
        .host_en_in(en_n[0]), .wire_out(multiplier_low_word_bus_in));
    mac_host_port #(.W(16)) u_high (.clk_in(clk_sys_in),
        .dev_data_in(high_product_bus_out),
        .dev_oe_in(high_product_bus_oe_out), .host_data_in(hd[31:16]),
        .host_en_in(en_n[1]), .wire_out(high_product_bus_in));
    mac_host_port #(.W(3)) u_ext (.clk_in(clk_sys_in),
        .dev_data_in(extension_bus_out), .dev_oe_in(extension_bus_oe_out),
        .host_data_in(hd[34:32]), .host_en_in(en_n[2]),
        .wire_out(extension_bus_in));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : step
    task automatic pulse(input int i);
        pclk[i] <= 1'b1;
        step(2);
        pclk[i] <= 1'b0;
        step(2);
    endtask : pulse
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        step(1);
        penable_in <= 1'b1;
        n = 0;
        do begin
            step(1);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            end_sim;
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        step(1);
    endtask : apb
    function automatic logic [34:0] ext35(input logic [15:0] v, input logic f);
        return f ? {{19{v[15]}}, v} : {19'h0, v};
    endfunction : ext35
    task automatic see;
        en_n <= 3'h0;
        step(3);
        chk({extension_bus_in, high_product_bus_in,
             multiplier_low_word_bus_in}, acc);
    endtask : see
    task automatic mac(input logic [15:0] x, input logic [15:0] y,
                       input logic [3:0] c);
        logic [34:0] p;
        multiplicand_in <= x;
        hd[15:0] <= y;
        ctl <= c;
        en_n <= 3'h7;
        step(1);
        pulse(0);
        pulse(1);
        pulse(2);
        p = ext35(x, c[0]) * ext35(y, c[0]) + (c[1] ? 35'h8000 : 35'h0);
        acc = !c[2] ? p : c[3] ? p - acc : p + acc;
        see();
    endtask : mac
    task automatic preload(input logic [34:0] v, input logic [2:0] e);
        hd <= v;
        en_n <= e;
        port_load_sel_in <= 1'b1;
        step(1);
        pulse(2);
        port_load_sel_in <= 1'b0;
        acc = {e[2] ? v[34:32] : acc[34:32], e[1] ? v[31:16] : acc[31:16],
               e[0] ? v[15:0] : acc[15:0]};
        see();
    endtask : preload
    task automatic t_modes;
        for (int i = 0; i < 16; i++) begin
            mac(16'h8001 + 16'(i * 16'h1111),
                16'hfff3 - 16'(i), 4'(i));
            apb(1'b0, `MAC_OFF_CONTROL, 32'h0);
            chk(35'(rd[3:0]), 35'(i));
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_pre;
        preload(35'h7_ffff_ffff, 3'h7);
        mac(16'h0001, 16'h0001, 4'h4);
        preload(35'h1_2345_6789, 3'h2);
        preload(35'h5_0000_abcd, 3'h5);
        $display("preload done");
    endtask : t_pre
    task automatic t_float;
        port_load_sel_in <= 1'b1;
        en_n <= 3'h0;
        step(2);
        chk(35'({extension_bus_oe_out, high_product_bus_oe_out,
                 multiplier_low_word_bus_oe_out}), 35'h0);
        port_load_sel_in <= 1'b0;
        en_n <= 3'h5;
        step(2);
        chk(35'({extension_bus_oe_out, high_product_bus_oe_out,
                 multiplier_low_word_bus_oe_out}), 35'h2);
        en_n <= 3'h2;
        step(2);
        chk(35'({extension_bus_oe_out, high_product_bus_oe_out,
                 multiplier_low_word_bus_oe_out}), 35'h5);
        $display("float done");
    endtask : t_float
    task automatic t_apb;
        apb(1'b0, 8'h20, 32'h0);
        chk(35'({er, rd}), 35'h1_0000_0000);
        apb(1'b1, `MAC_OFF_LOW_WORD, 32'hffff);
        apb(1'b0, `MAC_OFF_LOW_WORD, 32'h0);
        chk(35'(rd), 35'(acc[15:0]));
        apb(1'b0, `MAC_OFF_HIGH_WORD, 32'h0);
        chk(35'(rd), 35'(acc[31:16]));
        apb(1'b0, `MAC_OFF_EXT_BITS, 32'h0);
        chk(35'(rd), 35'(acc[34:32]));
        apb(1'b0, `MAC_OFF_OPERANDS, 32'h0);
        chk(35'(rd), 35'h0_0001_0001);
        apb(1'b1, `MAC_OFF_CONTROL, 32'h100);
        acc = '0;
        step(2);
        see();
        $display("registers done");
    endtask : t_apb
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        step(6);
        srst_in <= 1'b0;
        step(1);
        t_float();
        t_modes();
        t_pre();
        t_apb();
        end_sim();
    end
endmodule : multiply_accumulate_unit_bench
bind multiply_accumulate_unit mac_unit_checker #(.OPW(OPW), .EXTW(EXTW))
    u_chk (.*);
